//--- sdc_map.svh
/*
  Offsets, field positions, codes and reset values of the drive command slave.
  Assumes inclusion by bare name from any design file that needs them.
*/
`ifndef SDC_MAP_SVH
`define SDC_MAP_SVH
// Command register offsets
`define SDC_REG_RSVD   16'h2400
`define SDC_REG_OPCMD  16'h2401
`define SDC_REG_FREQ   16'h2402
`define SDC_REG_TORQ   16'h2403
`define SDC_MAP_END    17'h02404
// Function codes
`define SDC_FN_READ    8'h03
`define SDC_FN_WRITE1  8'h06
`define SDC_FN_LOOP    8'h08
`define SDC_FN_WRITEN  8'h10
// Exception marking and codes, broadcast station
`define SDC_EXC_BIT    8'h80
`define SDC_EXC_FUNC   8'h01
`define SDC_EXC_ADDR   8'h02
`define SDC_EXC_DATA   8'h03
`define SDC_BCAST      8'h00
// Limits
`define SDC_MAX_WORDS  16'd20
`define SDC_BUF_DEPTH  7'd64
`define SDC_TORQ_LIM   17'sh04000
// Check field
`define SDC_CRC_INIT   16'hFFFF
`define SDC_CRC_POLY   16'hA001
// Operation word fields and reset values
`define SDC_OP_RUN     0
`define SDC_OP_REV     1
`define SDC_OP_EFLT    2
`define SDC_OP_FRST    3
`define SDC_OP_TERM    8
`define SDC_REG_RESET  16'h0000
`endif

//--- sdc_pkg.sv
/*
  Types shared by the drive command slave.
  Assumes nothing of its surroundings.
*/
package sdc_pkg;
  typedef logic [7:0] sdc_byte_t;
  // Frame handling states
  typedef enum logic [3:0] {
    S_IDLE, S_CHECK, S_DECODE, S_VALID, S_WRITE,
    S_READ, S_REPLY, S_TX_LOAD, S_TX_WAIT
  } sdc_state_t;
endpackage : sdc_pkg

//--- sdc_crc_if.sv
/*
  Carrier between the command slave and its check-field unit.
  Assumes both ends share one clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface sdc_crc_if;
  logic        clr;   // Preset to all ones
  logic        en;    // Fold data in this cycle
  logic [7:0]  data;  // Byte to fold
  logic [15:0] crc;   // Running check value
  modport calc (input clr, input en, input data, output crc);
  modport user (output clr, output en, output data, input crc);
endinterface : sdc_crc_if
`default_nettype wire

//--- sdc_crc_unit.sv
/*
  Running CRC-16, one byte per clock, least significant bit first.
  Assumes clr and en come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdc_map.svh"
module sdc_crc_unit (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  sdc_crc_if.calc  crc_bus
);
  import sdc_pkg::*;

  // Eight shift steps of the reflected polynomial
  function automatic logic [15:0] crc_step(input logic [15:0] c_in,
                                           input logic [7:0] d);
    logic [15:0] c;
    c = c_in ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
    begin
      c = c[0] ? ((c >> 1) ^ `SDC_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step

  // Clear wins over fold so a new frame never inherits state
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      crc_bus.crc <= `SDC_CRC_INIT;
    else if (crc_bus.clr)
      crc_bus.crc <= `SDC_CRC_INIT;
    else if (crc_bus.en)
      crc_bus.crc <= crc_step(crc_bus.crc, crc_bus.data);
  end
endmodule : sdc_crc_unit
`default_nettype wire

//--- sdc_cmd_slave.sv
/*
  Serial drive command slave: takes RTU request bytes, checks them,
  executes reads and writes of the command registers and sends replies.
  Assumes a byte receiver and transmitter on the same clock, and a
  receiver that pulses rx_frame_end_i after the inter-frame silence.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sdc_map.svh"
module sdc_cmd_slave (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [7:0]        station_addr_i,
  input  wire sdc_pkg::sdc_byte_t rx_data_i,
  input  wire logic              rx_valid_i,
  input  wire logic              rx_frame_end_i,
  input  wire logic              tx_ready_i,
  output sdc_pkg::sdc_byte_t     tx_data_o,
  output logic                   tx_valid_o,
  output logic                   busy_o,
  output logic                   run_cmd_o,
  output logic                   reverse_cmd_o,
  output logic                   remote_external_fault_o,
  output logic                   fault_reset_o,
  output logic [7:0]             terminal_cmd_o,
  output logic [15:0]            freq_setpoint_o,
  output logic [15:0]            torque_setpoint_o,
  output logic                   link_error_warning_display_o,
  output logic [7:0]             link_error_code_o
);
  import sdc_pkg::*;

  //****************************************
  // Storage
  //****************************************
  sdc_state_t  state_reg;                      // Frame sequencer
  sdc_byte_t   buf_mem [0:`SDC_BUF_DEPTH-1];   // Request, then reply
  logic [6:0]  cnt_reg;                        // Bytes received
  logic        ovf_reg;                        // Frame too long
  logic [7:0]  fn_reg;                         // Function code
  logic [7:0]  exc_reg;                        // Exception, zero if none
  logic        bcast_reg;                      // Station 0 request
  logic [15:0] start_reg;                      // First register
  logic [15:0] qty_reg;                        // Word count field
  logic [5:0]  word_reg;                       // Word index
  logic [5:0]  ptr_reg;                        // Byte position of word
  logic [6:0]  len_reg;                        // Reply length, no CRC
  logic [6:0]  tx_idx_reg;                     // Byte being sent
  logic [15:0] op_cmd_reg;                     // Operation word
  logic [15:0] freq_reg;                       // Frequency setpoint
  logic [15:0] torq_reg;                       // Torque setpoint
  logic        err_reg;                        // Warning shown
  logic [7:0]  err_code_reg;                   // Code shown
  logic        tx_valid_reg;                   // Byte offered
  sdc_byte_t   tx_data_reg;                    // Byte on offer
  logic        busy_reg;                       // Not idle

  sdc_crc_if crc_bus ();

  sdc_crc_unit u_crc (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .crc_bus   (crc_bus)
  );

  //****************************************
  // Helpers
  //****************************************
  // Range lies inside the command area
  function automatic logic in_map(input logic [15:0] a, input logic [15:0] q);
    return (a >= `SDC_REG_RSVD) && (({1'b0, a} + {1'b0, q}) <= `SDC_MAP_END);
  endfunction : in_map

  // Torque value inside the signed limit
  function automatic logic torq_ok(input logic [15:0] v);
    return ($signed({v[15], v}) <= `SDC_TORQ_LIM) &&
           ($signed({v[15], v}) >= -`SDC_TORQ_LIM);
  endfunction : torq_ok

  logic        rx_full;
  logic        frame_ok;
  logic [15:0] eff_qty;
  logic [5:0]  base_ptr;
  logic [15:0] cur_addr;
  logic [15:0] cur_data;
  logic        last_word;
  logic [7:0]  dec_exc;
  logic [15:0] rd_val;
  sdc_byte_t   tx_sel;
  logic        tx_done;

  assign rx_full   = (cnt_reg == `SDC_BUF_DEPTH);
  // Length, CRC residue and station must all agree
  assign frame_ok  = !ovf_reg && (cnt_reg >= 7'd4) && (crc_bus.crc == 16'h0000) &&
                     ((buf_mem[0] == station_addr_i) || (buf_mem[0] == `SDC_BCAST));
  assign eff_qty   = (fn_reg == `SDC_FN_WRITE1) ? 16'h0001 : qty_reg;
  assign base_ptr  = (fn_reg == `SDC_FN_WRITE1) ? 6'd4 :
                     ((fn_reg == `SDC_FN_READ) ? 6'd3 : 6'd7);
  assign cur_addr  = start_reg + {10'h000, word_reg};
  // Values always travel as two bytes, high first
  assign cur_data  = {buf_mem[ptr_reg], buf_mem[6'(ptr_reg + 6'd1)]};
  assign last_word = (({10'h000, word_reg} + 16'h0001) == eff_qty);
  assign tx_done   = (tx_idx_reg == 7'(len_reg + 7'd1));

  // Request screening before any side effect
  always_comb
  begin
    dec_exc = 8'h00;
    case (fn_reg)
      `SDC_FN_READ:
        if (cnt_reg != 7'd8 || qty_reg == 16'h0 || qty_reg > `SDC_MAX_WORDS)
          dec_exc = `SDC_EXC_DATA;
        else if (!in_map(start_reg, qty_reg))
          dec_exc = `SDC_EXC_ADDR;
      `SDC_FN_WRITE1:
        if (cnt_reg != 7'd8)
          dec_exc = `SDC_EXC_DATA;
        else if (!in_map(start_reg, 16'h0001))
          dec_exc = `SDC_EXC_ADDR;
      `SDC_FN_LOOP:
        dec_exc = 8'h00;
      `SDC_FN_WRITEN:
        // Counts must agree before a single word is touched
        if (qty_reg == 16'h0 || qty_reg > `SDC_MAX_WORDS ||
            {8'h00, buf_mem[6]} != {qty_reg[14:0], 1'b0} ||
            {2'b00, cnt_reg} != (9'd9 + {1'b0, buf_mem[6]}))
          dec_exc = `SDC_EXC_DATA;
        else if (!in_map(start_reg, qty_reg))
          dec_exc = `SDC_EXC_ADDR;
      default:
        dec_exc = `SDC_EXC_FUNC;
    endcase
  end

  // Read data; the reserved word reads as zero
  always_comb
  begin
    case (cur_addr)
      `SDC_REG_OPCMD: rd_val = op_cmd_reg;
      `SDC_REG_FREQ:  rd_val = freq_reg;
      `SDC_REG_TORQ:  rd_val = torq_reg;
      default:        rd_val = 16'h0000;
    endcase
  end

  // Reply bytes, then CRC low and high
  always_comb
  begin
    if (tx_idx_reg < len_reg)
      tx_sel = buf_mem[tx_idx_reg[5:0]];
    else if (tx_idx_reg == len_reg)
      tx_sel = crc_bus.crc[7:0];
    else
      tx_sel = crc_bus.crc[15:8];
  end

  // One CRC unit serves receive and transmit, cleared between them
  assign crc_bus.clr  = (state_reg == S_REPLY) ||
                        (state_reg == S_CHECK && !frame_ok) ||
                        (state_reg == S_TX_WAIT && tx_ready_i && tx_done);
  assign crc_bus.en   = (state_reg == S_IDLE && rx_valid_i && !rx_full) ||
                        (state_reg == S_TX_WAIT && tx_ready_i && tx_idx_reg < len_reg);
  assign crc_bus.data = (state_reg == S_IDLE) ? rx_data_i : tx_data_reg;

  //****************************************
  // Sequencer
  //****************************************
  // Bytes arriving outside idle are dropped: the master must wait for a reply
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_reg  <= S_IDLE;
      cnt_reg    <= 7'd0;
      ovf_reg    <= 1'b0;
      fn_reg     <= 8'h00;
      exc_reg    <= 8'h00;
      bcast_reg  <= 1'b0;
      start_reg  <= 16'h0000;
      qty_reg    <= 16'h0000;
      word_reg   <= 6'd0;
      ptr_reg    <= 6'd0;
      len_reg    <= 7'd0;
      tx_idx_reg <= 7'd0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          if (rx_valid_i && !rx_full)
            cnt_reg <= cnt_reg + 7'd1;
          else if (rx_valid_i)
            ovf_reg <= 1'b1;
          if (rx_frame_end_i)
            state_reg <= S_CHECK;
        end
        S_CHECK:
          if (frame_ok)
          begin
            fn_reg    <= buf_mem[1];
            start_reg <= {buf_mem[2], buf_mem[3]};
            qty_reg   <= {buf_mem[4], buf_mem[5]};
            bcast_reg <= (buf_mem[0] == `SDC_BCAST);
            state_reg <= S_DECODE;
          end
          else
          begin
            // Corrupt or foreign frame: silently dropped
            cnt_reg   <= 7'd0;
            ovf_reg   <= 1'b0;
            state_reg <= S_IDLE;
          end
        S_DECODE:
        begin
          exc_reg  <= dec_exc;
          word_reg <= 6'd0;
          ptr_reg  <= base_ptr;
          if (dec_exc != 8'h00 || fn_reg == `SDC_FN_LOOP)
            state_reg <= S_REPLY;
          else if (fn_reg == `SDC_FN_READ)
            state_reg <= S_READ;
          else
            state_reg <= S_VALID;
        end
        S_VALID:
          // Whole request checked before the first write
          if (cur_addr == `SDC_REG_TORQ && !torq_ok(cur_data))
          begin
            exc_reg   <= `SDC_EXC_DATA;
            state_reg <= S_REPLY;
          end
          else if (last_word)
          begin
            word_reg  <= 6'd0;
            ptr_reg   <= base_ptr;
            state_reg <= S_WRITE;
          end
          else
          begin
            word_reg <= word_reg + 6'd1;
            ptr_reg  <= 6'(ptr_reg + 6'd2);
          end
        S_WRITE, S_READ:
          if (last_word)
            state_reg <= S_REPLY;
          else
          begin
            word_reg <= word_reg + 6'd1;
            ptr_reg  <= 6'(ptr_reg + 6'd2);
          end
        S_REPLY:
        begin
          if (exc_reg != 8'h00)
            len_reg <= 7'd3;
          else if (fn_reg == `SDC_FN_READ)
            len_reg <= 7'(7'd3 + {qty_reg[5:0], 1'b0});
          else if (fn_reg == `SDC_FN_LOOP)
            len_reg <= 7'(cnt_reg - 7'd2);
          else
            len_reg <= 7'd6;
          tx_idx_reg <= 7'd0;
          if (bcast_reg)
          begin
            cnt_reg   <= 7'd0;
            state_reg <= S_IDLE;
          end
          else
            state_reg <= S_TX_LOAD;
        end
        S_TX_LOAD:
          state_reg <= S_TX_WAIT;
        S_TX_WAIT:
          if (tx_ready_i && tx_done)
          begin
            cnt_reg   <= 7'd0;
            state_reg <= S_IDLE;
          end
          else if (tx_ready_i)
          begin
            tx_idx_reg <= tx_idx_reg + 7'd1;
            state_reg  <= S_TX_LOAD;
          end
      endcase
    end
  end

  //****************************************
  // Buffer
  //****************************************
  // Reply is built in place; header fields were latched first
  always_ff @(posedge ref_clk_i)
  begin
    if (state_reg == S_IDLE && rx_valid_i && !rx_full)
      buf_mem[cnt_reg[5:0]] <= rx_data_i;
    else if (state_reg == S_READ)
    begin
      buf_mem[ptr_reg]                <= rd_val[15:8];
      buf_mem[6'(ptr_reg + 6'd1)]     <= rd_val[7:0];
    end
    else if (state_reg == S_REPLY && exc_reg != 8'h00)
    begin
      buf_mem[1] <= fn_reg | `SDC_EXC_BIT;
      buf_mem[2] <= exc_reg;
    end
    else if (state_reg == S_REPLY && fn_reg == `SDC_FN_READ)
      buf_mem[2] <= {qty_reg[6:0], 1'b0};
  end

  //****************************************
  // Command registers
  //****************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_cmd_reg <= `SDC_REG_RESET;
      freq_reg   <= `SDC_REG_RESET;
      torq_reg   <= `SDC_REG_RESET;
    end
    else if (state_reg == S_WRITE)
      case (cur_addr)
        `SDC_REG_OPCMD: op_cmd_reg <= cur_data;
        `SDC_REG_FREQ:  freq_reg   <= cur_data;
        `SDC_REG_TORQ:  torq_reg   <= cur_data;
        default:        ;
      endcase
  end

  // Warning stays until the next good request
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      err_reg      <= 1'b0;
      err_code_reg <= 8'h00;
    end
    else if (state_reg == S_REPLY)
    begin
      err_reg <= (exc_reg != 8'h00);
      if (exc_reg != 8'h00)
        err_code_reg <= exc_reg;
    end
  end

  // Transmit offer held until taken
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      tx_valid_reg <= 1'b0;
      tx_data_reg  <= 8'h00;
      busy_reg     <= 1'b0;
    end
    else
    begin
      busy_reg <= (state_reg != S_IDLE);
      if (state_reg == S_TX_LOAD)
      begin
        tx_valid_reg <= 1'b1;
        tx_data_reg  <= tx_sel;
      end
      else if (state_reg == S_TX_WAIT && tx_ready_i)
        tx_valid_reg <= 1'b0;
    end
  end

  assign tx_data_o                    = tx_data_reg;
  assign tx_valid_o                   = tx_valid_reg;
  assign busy_o                       = busy_reg;
  assign run_cmd_o                    = op_cmd_reg[`SDC_OP_RUN];
  assign reverse_cmd_o                = op_cmd_reg[`SDC_OP_REV];
  assign remote_external_fault_o      = op_cmd_reg[`SDC_OP_EFLT];
  assign fault_reset_o                = op_cmd_reg[`SDC_OP_FRST];
  assign terminal_cmd_o               = op_cmd_reg[`SDC_OP_TERM +: 8];
  assign freq_setpoint_o              = freq_reg;
  assign torque_setpoint_o            = torq_reg;
  assign link_error_warning_display_o = err_reg;
  assign link_error_code_o            = err_code_reg;

  //****************************************
  // Checks
  //****************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  AST_WRITE_ONE: assert property (state_reg == S_WRITE && cur_addr == `SDC_REG_FREQ
    |=> freq_setpoint_o == $past(cur_data)) else $error("frequency write lost");
  AST_MAX_WORDS: assert property (state_reg == S_WRITE
    |-> eff_qty != 16'h0 && eff_qty <= `SDC_MAX_WORDS) else $error("word count over limit");
  AST_EXC_REPLY: assert property (state_reg == S_REPLY && exc_reg != 8'h00
    |=> buf_mem[1][7] && buf_mem[2] == $past(exc_reg) && len_reg == 7'd3)
    else $error("bad exception reply");
  AST_DISPLAY: assert property (state_reg == S_REPLY && exc_reg != 8'h00
    |=> link_error_warning_display_o && link_error_code_o == $past(exc_reg))
    else $error("warning not shown");
  AST_OP_WORD: assert property (state_reg == S_WRITE && cur_addr == `SDC_REG_OPCMD
    |=> run_cmd_o == $past(cur_data[0]) && terminal_cmd_o == $past(cur_data[15:8]))
    else $error("operation word decode");
  AST_TORQ_LIM: assert property (state_reg == S_WRITE && cur_addr == `SDC_REG_TORQ
    |-> torq_ok(cur_data)) else $error("torque out of range written");
  AST_RSVD: assert property (state_reg == S_WRITE && cur_addr == `SDC_REG_RSVD
    |=> $stable(op_cmd_reg) && $stable(freq_reg) && $stable(torq_reg))
    else $error("reserved write changed state");
  AST_BAD_CRC: assert property (state_reg == S_CHECK && crc_bus.crc != 16'h0
    |=> state_reg == S_IDLE ##1 !busy_o) else $error("bad frame executed");
  AST_BCAST: assert property (state_reg == S_REPLY && bcast_reg
    |=> state_reg == S_IDLE && !tx_valid_o) else $error("broadcast answered");
  AST_FUNC: assert property (state_reg == S_DECODE && dec_exc == `SDC_EXC_FUNC
    |=> exc_reg == `SDC_EXC_FUNC ##1 buf_mem[1] == (fn_reg | `SDC_EXC_BIT))
    else $error("unknown function accepted");
  AST_READ_LEN: assert property (state_reg == S_REPLY && exc_reg == 8'h00
    && fn_reg == `SDC_FN_READ |=> len_reg == 7'(7'd3 + {qty_reg[5:0], 1'b0}))
    else $error("read reply length");
  AST_COUNTS: assert property (state_reg == S_DECODE && fn_reg == `SDC_FN_WRITEN
    && qty_reg > `SDC_MAX_WORDS |=> exc_reg == `SDC_EXC_DATA ##1 state_reg != S_WRITE)
    else $error("oversized write accepted");

  COV_WRITE:  cover property (state_reg == S_WRITE && fn_reg == `SDC_FN_WRITEN ##1
                              state_reg == S_WRITE);
  COV_READ:   cover property (state_reg == S_READ ##[1:40] state_reg == S_TX_LOAD);
  COV_EXC:    cover property (state_reg == S_REPLY && exc_reg != 8'h00 && !bcast_reg);
  COV_BCAST:  cover property (state_reg == S_REPLY && bcast_reg);
endmodule : sdc_cmd_slave
`default_nettype wire

//--- sdc_master_model.sv
/*
  Master-side model of the serial link: sends request frames with their
  check field and takes reply bytes. Assumes the slave's clock.
*/
`timescale 1ns/100ps
`default_nettype none
module sdc_master_model (
  input  wire logic ref_clk_i,
  input  wire logic slow_i,
  output logic [7:0] rx_data_o,
  output logic       rx_valid_o,
  output logic       rx_frame_end_o,
  output logic       tx_ready_o
);
  // ****************
  // Check field
  // ****************
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c ^= {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc
  // Quiet lines until the first frame
  initial
  begin
    rx_data_o      = 8'h00;
    rx_valid_o     = 1'b0;
    rx_frame_end_o = 1'b0;
  end
  // Slow taker stalls every other cycle, so replies must hold
  // Only this process drives the taker; an unknown start settles to high
  always @(posedge ref_clk_i)
    tx_ready_o <= slow_i ? (tx_ready_o !== 1'b1) : 1'b1;
  // Sends one frame; bad flips a check bit
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = crc(q) ^ {15'h0000, bad};
    q.push_back(c[7:0]);
    q.push_back(c[15:8]);
    foreach (q[i])
    begin
      @(posedge ref_clk_i);
      rx_data_o      <= q[i];
      rx_valid_o     <= 1'b1;
      rx_frame_end_o <= (i == q.size() - 1);
    end
    @(posedge ref_clk_i);
    rx_data_o      <= ~rx_data_o; // Stale byte never repeats
    rx_valid_o     <= 1'b0;
    rx_frame_end_o <= 1'b0;
  endtask : send
endmodule : sdc_master_model
`default_nettype wire

//--- test_serial_drive_command_slave.sv
/*
  Self-checking bench of the drive command slave.
  Assumes the design and the master model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module test_serial_drive_command_slave;
  import sdc_pkg::*;
  typedef logic [7:0] sdc_bq_t[$];
  logic ref_clk_i, rst_n_i, slow, rxv, rxe, txr, txv, busy;
  logic run, rev, eflt, frst, warn;
  logic [7:0] stn, rxd, term, code;
  sdc_byte_t txd;
  logic [15:0] freq, torq;
  sdc_bq_t exp_q, none;
  int seed = 5198;
  int failures, check_count, ntest;
  sdc_cmd_slave DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .station_addr_i(stn),
    .rx_data_i(rxd), .rx_valid_i(rxv), .rx_frame_end_i(rxe), .tx_ready_i(txr),
    .tx_data_o(txd), .tx_valid_o(txv), .busy_o(busy), .run_cmd_o(run),
    .reverse_cmd_o(rev), .remote_external_fault_o(eflt), .fault_reset_o(frst),
    .terminal_cmd_o(term), .freq_setpoint_o(freq), .torque_setpoint_o(torq),
    .link_error_warning_display_o(warn), .link_error_code_o(code));
  sdc_master_model M (.ref_clk_i(ref_clk_i), .slow_i(slow), .rx_data_o(rxd),
    .rx_valid_o(rxv), .rx_frame_end_o(rxe), .tx_ready_o(txr));
  // ****************
  // Clock, checks, closing
  // ****************
  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end
  task automatic chk(input logic [15:0] s, e);
    check_count++;
    if (s !== e)
      $display("mismatch at %0t: saw %h want %h", $time, s, e);
    if (s !== e)
      failures++;
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  // Each taken reply byte meets the oldest note; a stray byte always fails
  always @(posedge ref_clk_i)
    if (txv === 1'b1 && txr === 1'b1)
      chk({8'h00, txd}, exp_q.size() ? {8'h00, exp_q.pop_front()} : 16'h0100);
  // Hang guard, well beyond the few hundred cycles the tests need
  initial
  begin
    #500000;
    failures++;
    summarize();
  end
  // Notes the reply, sends the frame, waits bounded for quiet
  task automatic xfer(input logic [7:0] a, input sdc_bq_t q, r, input bit bad);
    logic [15:0] c;
    if (r.size() != 0)
    begin
      r.push_front(a);
      c = M.crc(r);
      exp_q = {exp_q, r, c[7:0], c[15:8]};
    end
    q.push_front(a);
    M.send(q, bad);
    repeat (4) @(posedge ref_clk_i);
    for (int i = 0; i < 800 && (busy !== 1'b0 || exp_q.size() != 0); i++)
      @(posedge ref_clk_i);
    // A reply that never ends or never comes counts against the run
    chk({busy, 15'(exp_q.size())}, 16'h0000);
    repeat (10) @(posedge ref_clk_i);
    ntest++;
    $display("test %0d done", ntest);
  endtask : xfer
  // ****************
  // Scenarios
  // ****************
  initial
  begin
    logic [15:0] f, o;
    sdc_bq_t q;
    rst_n_i = 1'b0;
    slow = 1'b0;
    stn = 8'h11;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    chk(freq, 16'h0000);
    f = 16'($random(seed));
    q = '{8'h06, 8'h24, 8'h02, f[15:8], f[7:0]};
    xfer(8'h11, q, q, 0);
    chk(freq, f);
    o = 16'($random(seed));
    f = 16'($random(seed));
    slow <= 1'b1;
    q = '{8'h10, 8'h24, 8'h01, 8'h00, 8'h03, 8'h06, o[15:8], o[7:0], f[15:8], f[7:0],
      8'h40, 8'h00};
    xfer(8'h11, q, '{8'h10, 8'h24, 8'h01, 8'h00, 8'h03}, 0);
    slow <= 1'b0;
    chk({term, 4'h0, frst, eflt, rev, run}, o & 16'hFF0F);
    chk(freq, f);
    chk(torq, 16'h4000);
    xfer(8'h11, '{8'h10, 8'h24, 8'h01, 8'h00, 8'h15, 8'h2A}, '{8'h90, 8'h03}, 0);
    chk({warn, code}, 16'h0103);
    q = '{8'h08, 8'h00, 8'h00, 8'hA5, 8'h5A};
    xfer(8'h11, q, q, 0);
    chk(warn, 1'b0);
    xfer(8'h11, '{8'h05, 8'h24, 8'h02, 8'h00, 8'h01}, '{8'h85, 8'h01}, 0);
    chk({warn, code}, 16'h0101);
    q = '{8'h03, 8'h24, 8'h02, 8'h00, 8'h02};
    xfer(8'h11, q, '{8'h03, 8'h04, f[15:8], f[7:0], 8'h40, 8'h00}, 0);
    // Range running past the command area is refused
    xfer(8'h11, '{8'h03, 8'h24, 8'h03, 8'h00, 8'h02}, '{8'h83, 8'h02}, 0);
    chk({warn, code}, 16'h0102);
    xfer(8'h11, '{8'h06, 8'h24, 8'h02, ~f[15:8], 8'h00}, none, 1);
    xfer(8'h12, '{8'h06, 8'h24, 8'h02, ~f[15:8], 8'h00}, none, 0);
    chk(freq, f);
    xfer(8'h00, '{8'h06, 8'h24, 8'h02, 8'h12, 8'h34}, none, 0);
    chk(freq, 16'h1234);
    q = '{8'h06, 8'h24, 8'h00, 8'hFF, 8'hFF};
    xfer(8'h11, q, q, 0);
    xfer(8'h11, '{8'h03, 8'h24, 8'h00, 8'h00, 8'h01}, '{8'h03, 8'h02, 8'h00, 8'h00}, 0);
    chk({term, 4'h0, frst, eflt, rev, run}, o & 16'hFF0F);
    xfer(8'h11, '{8'h06, 8'h24, 8'h03, 8'h40, 8'h01}, '{8'h86, 8'h03}, 0);
    chk(torq, 16'h4000);
    summarize();
  end
endmodule : test_serial_drive_command_slave
`default_nettype wire
